/* rtl/lsscan_pkg.sv */
// Package with constants for the linear sensor scan readout
package lsscan_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned PIXEL_COUNT = 1024;
    localparam int unsigned CYCLES_PER_PIXEL = 4;
    localparam int unsigned PIX_W = 10;
    localparam int unsigned SCAN_PERIOD_CLKS = 4104;
    // Sensor clock limits in kHz, kept for reference; neither the RTL nor the bench uses them
    localparam int unsigned SENSOR_CLK_MIN_KHZ = 10;
    localparam int unsigned SENSOR_CLK_MAX_KHZ = 800;
    localparam int unsigned PIXEL_RATE_MAX_KHZ = 200;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] PHASE_TRIG = 2'h1;
    localparam logic [9:0] PIX_RESET = 10'h000;
    localparam logic [9:0] PIX_LAST = 10'h3FF;
    localparam int unsigned INTEG_W = 24;
    typedef enum logic [2:0] {
        LSS_IDLE = 3'b001,
        LSS_ARMED = 3'b010,
        LSS_SCAN = 3'b100
    } lss_state_type;
endpackage

/* rtl/lss_buf_if.sv */
// Interface carrying pixel words between the scanner and the output buffer
`timescale 1ns/1ps
interface lss_buf_if #(parameter int unsigned W = 11);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

/* rtl/lss_skid_buf.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module lss_skid_buf #(
    parameter int unsigned W = 11
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Filling side
    lss_buf_if.dst in_p,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] cnt_q;
    wire push = in_p.valid && in_p.ready;
    wire pop = out_valid && out_ready;

    // Ready only while a slot is free, so a stalled drain backs up the source
    assign in_p.ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_ptr_q];

    // Storage and pointers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= in_p.data;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

/* rtl/lss_scan_top.sv */
// Scan readout timing generator of a 1024-pixel linear image sensor
`timescale 1ns/1ps
module lss_scan_top #(
    parameter int unsigned PIXELS = lsscan_pkg::PIXEL_COUNT
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Controller pins, asynchronous to clk
    input wire logic sensor_clk,
    input wire logic scan_start_pulse,
    input wire logic gain_select_level,
    // Sensor outputs
    output logic trig_out,
    output logic scan_done_out,
    // Pixel stream: index, gain flag, and integration time in sensor clocks
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [lsscan_pkg::PIX_W-1:0] pix_index,
    output logic pix_high_gain,
    output logic [lsscan_pkg::INTEG_W-1:0] integ_clks,
    output logic overrun_out
);
    localparam int unsigned DW = lsscan_pkg::PIX_W + 1;

    // Two-stage synchronisers for start and gain, three stages for the sensor clock
    logic sck_s1_q, sck_s2_q, sck_s3_q;
    logic st_s1_q, st_s2_q;
    logic g_s1_q, g_s2_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Idle levels of the pins, so no false edge or start follows reset
            sck_s1_q <= 1'b1;
            sck_s2_q <= 1'b1;
            sck_s3_q <= 1'b1;
            st_s1_q <= 1'b1;
            st_s2_q <= 1'b1;
            g_s1_q <= 1'b1;
            g_s2_q <= 1'b1;
        end else begin
            sck_s1_q <= sensor_clk;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            st_s1_q <= scan_start_pulse;
            st_s2_q <= st_s1_q;
            g_s1_q <= gain_select_level;
            g_s2_q <= g_s1_q;
        end
    end

    // Sensor clock edges as one-cycle enables; only stages two and three are compared
    wire sck_fall = sck_s3_q && !sck_s2_q;
    wire sck_rise = !sck_s3_q && sck_s2_q;
    wire start_low = !st_s2_q;

    lsscan_pkg::lss_state_type state_q, state_d;
    logic [1:0] phase_q;
    logic [lsscan_pkg::PIX_W-1:0] pix_q;
    logic done_q;
    logic trig_q;
    logic [lsscan_pkg::INTEG_W-1:0] integ_cnt_q;
    logic [lsscan_pkg::INTEG_W-1:0] integ_last_q;
    logic ovr_q;

    lss_buf_if #(.W(DW)) buf_p ();

    // Start sequence: the falling edge seen while start is low launches a scan
    wire start_hit = sck_fall && start_low;
    // Stall only at the emit point while the buffer is full, so no pixel is lost
    // and a held slot never repeats its trigger
    wire advance = sck_fall && (buf_p.ready || (phase_q != lsscan_pkg::PHASE_RESET));
    wire last_pix = (pix_q == lsscan_pkg::PIX_W'(PIXELS - 1));
    wire last_slot = last_pix && (phase_q == lsscan_pkg::PHASE_LAST);
    wire pix_emit = (state_q == lsscan_pkg::LSS_SCAN) && advance
                    && (phase_q == lsscan_pkg::PHASE_RESET);

    // Next state decode
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            lsscan_pkg::LSS_IDLE: begin
                if (start_hit) begin
                    state_d = lsscan_pkg::LSS_SCAN;
                end
            end
            lsscan_pkg::LSS_ARMED: begin
                state_d = lsscan_pkg::LSS_SCAN;
            end
            lsscan_pkg::LSS_SCAN: begin
                if (advance && last_slot) begin
                    state_d = lsscan_pkg::LSS_IDLE;
                end
            end
            default: begin
                state_d = lsscan_pkg::LSS_IDLE;
            end
        endcase
    end

    // State, pixel slot counter and phase within the slot
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= lsscan_pkg::LSS_IDLE;
            phase_q <= lsscan_pkg::PHASE_RESET;
            pix_q <= lsscan_pkg::PIX_RESET;
        end else begin
            state_q <= state_d;
            if (state_q == lsscan_pkg::LSS_IDLE && start_hit) begin
                phase_q <= lsscan_pkg::PHASE_RESET;
                pix_q <= lsscan_pkg::PIX_RESET;
            end else if (state_q == lsscan_pkg::LSS_SCAN && advance) begin
                phase_q <= phase_q + 2'h1;
                if (phase_q == lsscan_pkg::PHASE_LAST) begin
                    pix_q <= pix_q + 10'h001;
                end
            end
        end
    end

    // Trigger marks the mid-slot sampling point on a rising sensor clock edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trig_q <= 1'b0;
        end else if (sck_rise || sck_fall) begin
            trig_q <= (state_q == lsscan_pkg::LSS_SCAN) && sck_rise
                      && (phase_q == lsscan_pkg::PHASE_TRIG);
        end
    end

    // End of scan rises after the last slot and falls with the next start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_q <= 1'b0;
        end else if (state_q == lsscan_pkg::LSS_SCAN && advance && last_slot) begin
            done_q <= 1'b1;
        end else if (state_q == lsscan_pkg::LSS_IDLE && start_hit) begin
            done_q <= 1'b0;
        end
    end

    // Integration time: sensor clocks between successive starts, shared by every pixel
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            integ_cnt_q <= '0;
            integ_last_q <= '0;
        end else if (state_q == lsscan_pkg::LSS_IDLE && start_hit) begin
            integ_last_q <= integ_cnt_q;
            // The start fall itself opens the new interval
            integ_cnt_q <= lsscan_pkg::INTEG_W'(1);
        end else if (sck_fall && integ_cnt_q != '1) begin
            integ_cnt_q <= integ_cnt_q + 1'b1;
        end
    end

    // A start seen mid-scan is ignored and flagged, since the scan cannot restart
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ovr_q <= 1'b0;
        end else if (state_q == lsscan_pkg::LSS_SCAN && start_hit) begin
            ovr_q <= 1'b1;
        end else if (state_q == lsscan_pkg::LSS_IDLE && start_hit) begin
            ovr_q <= 1'b0;
        end
    end

    // Pixel words into the buffer, one per slot
    assign buf_p.valid = pix_emit;
    assign buf_p.data = {g_s2_q, pix_q};

    logic bo_valid;
    logic [DW-1:0] bo_data;
    lss_skid_buf #(.W(DW)) u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .in_p(buf_p),
        .out_valid(bo_valid),
        .out_ready(!pix_valid || pix_ready),
        .out_data(bo_data)
    );

    // Registered stream outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pix_valid <= 1'b0;
            pix_index <= '0;
            pix_high_gain <= 1'b0;
            integ_clks <= '0;
        end else if (!pix_valid || pix_ready) begin
            pix_valid <= bo_valid;
            if (bo_valid) begin
                pix_index <= bo_data[lsscan_pkg::PIX_W-1:0];
                pix_high_gain <= !bo_data[DW-1]; // Low level selects high gain
                integ_clks <= integ_last_q;
            end
        end
    end

    assign trig_out = trig_q;
    assign scan_done_out = done_q;
    assign overrun_out = ovr_q;
endmodule

/* sim/lss_scan_checker.sv */
// Port-level checker for the scan readout
`timescale 1ns/1ps
module lss_scan_checker #(
    parameter int unsigned PIXELS = 1024
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Controller pins
    input wire logic sensor_clk,
    input wire logic scan_start_pulse,
    input wire logic gain_select_level,
    // Sensor outputs and pixel stream
    input wire logic trig_out,
    input wire logic scan_done_out,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire logic [lsscan_pkg::PIX_W-1:0] pix_index,
    input wire logic pix_high_gain,
    input wire logic [lsscan_pkg::INTEG_W-1:0] integ_clks,
    input wire logic overrun_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [lsscan_pkg::PIX_W-1:0] nxt_q;
    logic [7:0] gap_q;
    // Next index due; clocks since the last trigger rise, saturating so the first rise passes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nxt_q <= '0;
            gap_q <= 8'hFF;
        end else begin
            if (pix_valid && pix_ready) nxt_q <= (pix_index == PIXELS - 1) ? '0 : pix_index + 1'h1;
            gap_q <= $rose(trig_out) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hFF};
        end
    end
    sequence idle_empty;
        scan_done_out && !pix_valid;
    endsequence
    chk_trig_high: assert property ($rose(trig_out) |-> sensor_clk)
        else $error("trigger rose with sensor clock low");
    chk_trig_width: assert property ($rose(trig_out) |-> trig_out[*8])
        else $error("trigger too short");
    // Slots cannot be closer than four periods of the fastest legal sensor clock
    chk_slot_gap: assert property ($rose(trig_out) |-> gap_q >= 8'h62)
        else $error("pixel slot too short");
    chk_idle_quiet: assert property (scan_done_out |-> !trig_out)
        else $error("trigger after end of scan");
    chk_index_order: assert property (pix_valid && pix_ready |-> pix_index == nxt_q)
        else $error("pixel index out of order");
    chk_stall_hold: assert property (pix_valid && !pix_ready |=> pix_valid
        && $stable(pix_index) && $stable(integ_clks) && $stable(pix_high_gain))
        else $error("word changed while stalled");
    chk_no_late_word: assert property (idle_empty ##1 scan_done_out |-> !pix_valid)
        else $error("word after end of scan");
    chk_overrun_set: assert property ($rose(overrun_out) |-> !scan_done_out)
        else $error("overrun outside a scan");
    chk_start_clear: assert property ($fell(scan_done_out) |-> !scan_start_pulse)
        else $error("scan began without start low");
endmodule

bind lss_scan_top lss_scan_checker #(.PIXELS(PIXELS)) u_chk (
    .clk(clk), .rst_b(rst_b), .sensor_clk(sensor_clk), .scan_start_pulse(scan_start_pulse),
    .gain_select_level(gain_select_level), .trig_out(trig_out), .scan_done_out(scan_done_out),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_index(pix_index),
    .pix_high_gain(pix_high_gain), .integ_clks(integ_clks), .overrun_out(overrun_out));

/* sim/lss_ctrl_model.sv */
// Behavioural external controller: sensor clock and start pulse
`timescale 1ns/1ps
module lss_ctrl_model #(
    parameter int HALF = 13
) (
    // Clock, reset and scan request
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start_req,
    // Sensor pins
    output logic sensor_clk,
    output logic scan_start_pulse
);
    int cnt;
    logic pend;
    initial begin
        sensor_clk = 1'b1;
        scan_start_pulse = 1'b1;
        cnt = 0;
        pend = 1'b0;
    end
    // Clock held during reset and for HALF clk after its release, then 50 percent duty at 2*HALF clk
    always @(posedge clk) begin
        if (start_req) pend <= 1'b1;
        if (!rst_b) cnt <= 0;
        else if (cnt == HALF - 1) begin
            cnt <= 0;
            sensor_clk <= ~sensor_clk;
            // Start changes only on rises, so exactly one fall sees it low
            if (!sensor_clk) scan_start_pulse <= !pend;
            if (!sensor_clk && pend) pend <= 1'b0;
        end else cnt <= cnt + 1;
    end
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the scan readout
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned PIXELS = 16;
    localparam int HALF = 13;
    localparam int PERIOD = (PIXELS * 4 + 8) * 2 * HALF;
    logic clk, rst_b, start_req, gain_select_level, pix_ready, stall_on, sc_d, tg_d;
    logic sensor_clk, scan_start_pulse, trig_out, scan_done_out, pix_valid, pix_high_gain;
    logic overrun_out;
    logic [lsscan_pkg::PIX_W-1:0] pix_index;
    logic [lsscan_pkg::INTEG_W-1:0] integ_clks;
    logic [35:0] notes[$];
    logic [35:0] n;
    int fails, check_count, falls, prev_t, trigs;
    int seed = 32'hF2A0067C;
    lss_ctrl_model #(.HALF(HALF)) u_ctrl (.clk(clk), .rst_b(rst_b), .start_req(start_req),
        .sensor_clk(sensor_clk), .scan_start_pulse(scan_start_pulse));
    lss_scan_top #(.PIXELS(PIXELS)) dut (.clk(clk), .rst_b(rst_b), .sensor_clk(sensor_clk),
        .scan_start_pulse(scan_start_pulse), .gain_select_level(gain_select_level),
        .trig_out(trig_out), .scan_done_out(scan_done_out), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_index(pix_index), .pix_high_gain(pix_high_gain),
        .integ_clks(integ_clks), .overrun_out(overrun_out));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp, input string what);
        cmp_word({23'h0, got}, {23'h0, exp}, what);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Pulse the start request; the model turns it into one pin cycle
    task automatic ask_start;
        start_req <= 1'b1;
        @(posedge clk);
        start_req <= 1'b0;
    endtask
    task automatic scan(input logic g, input logic chk, input logic early);
        int w;
        int t0;
        @(posedge clk);
        gain_select_level <= g;
        ask_start;
        w = 0;
        while (scan_start_pulse !== 1'b0 && w < 100) begin @(posedge clk); w++; end
        while (scan_start_pulse !== 1'b1 && w < 200) begin @(posedge clk); w++; end
        for (int i = 0; i < PIXELS; i++) notes.push_back({chk, 24'(falls - prev_t), ~g, 10'(i)});
        prev_t = falls;
        t0 = trigs;
        cmp_flag(overrun_out, 1'b0, "overrun after start");
        if (early) begin
            repeat (300) @(posedge clk);
            ask_start;
        end
        repeat (PERIOD - 400) @(posedge clk);
        while (scan_done_out !== 1'b1 && w < 5000) begin @(posedge clk); w++; end
        cmp_flag(scan_done_out, 1'b1, "end of scan");
        cmp_flag(overrun_out, early, "overrun flag");
        cmp_word(24'(trigs - t0), 24'(PIXELS), "trigger count");
        repeat (16 * HALF) @(posedge clk);
    endtask
    // Falls of the sensor clock, to measure the spacing of starts
    always @(posedge clk) begin
        sc_d <= sensor_clk;
        if (sc_d && !sensor_clk) falls <= falls + 1;
    end
    // Controller samples once per trigger rise and counts slots up to end of scan
    always @(posedge clk) begin
        tg_d <= trig_out;
        if (tg_d === 1'b0 && trig_out === 1'b1) trigs <= trigs + 1;
    end
    // Random backpressure; a held stall fills the buffer until it refuses
    always @(posedge clk) pix_ready <= !stall_on && ($random(seed) % 4 != 0);
    // Each accepted word is matched with the oldest note
    always @(posedge clk) begin
        if (rst_b && pix_valid === 1'b1 && pix_ready === 1'b1) begin
            cmp_flag(notes.size() > 0, 1'b1, "unexpected word");
            if (notes.size() > 0) begin
                n = notes.pop_front();
                cmp_word(24'(pix_index), 24'(n[9:0]), "pixel index");
                cmp_flag(pix_high_gain, n[10], "gain flag");
                if (n[35]) cmp_word(integ_clks, n[34:11], "integration");
            end
        end
    end
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        print_verdict;
    end
    initial begin
        rst_b = 1'b0;
        start_req = 1'b0;
        gain_select_level = 1'b1;
        pix_ready = 1'b0;
        stall_on = 1'b0;
        {fails, check_count, falls, prev_t, trigs} = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        scan(1'b1, 1'b0, 1'b0);
        stall_on <= 1'b1;
        fork
            scan(1'b0, 1'b1, 1'b1);
            begin repeat (600) @(posedge clk); stall_on <= 1'b0; end
        join
        scan(1'($random(seed)), 1'b1, 1'b0);
        repeat (200) @(posedge clk);
        cmp_word(24'(notes.size()), 24'h0, "words missing");
        print_verdict;
    end
endmodule
